// ### hdl/pdd_pkg.sv
package pdd_pkg;

    // Port geometry
    localparam int PDD_PIN_W  = 8;
    localparam int PDD_D_W    = 3;
    localparam int PDD_SYNC_W = 3 * PDD_PIN_W + PDD_D_W + 1;

    // Port index within a register group
    localparam logic [1:0] PDD_PA = 2'h0;
    localparam logic [1:0] PDD_PB = 2'h1;
    localparam logic [1:0] PDD_PC = 2'h2;
    localparam logic [1:0] PDD_PD = 2'h3;

    // Group base offsets; low two address bits pick the port
    localparam logic [7:0] PDD_DIN_BASE  = 8'h00;
    localparam logic [7:0] PDD_CTRL_BASE = 8'h04;
    localparam logic [7:0] PDD_DOUT_BASE = 8'h08;
    localparam logic [7:0] PDD_DIR_BASE  = 8'h0C;
    localparam logic [7:0] PDD_DRV_BASE  = 8'h10;

    // Values after reset and answer to unmapped reads
    localparam logic [7:0] PDD_RST_VAL  = 8'h00;
    localparam logic [7:0] PDD_UNMAPPED = 8'h00;

    // Drive select field layouts
    localparam logic [7:0] PDD_AB_OD_MASK   = 8'hF0;
    localparam logic [7:0] PDD_AB_SLEW_MASK = 8'h0F;
    localparam logic [7:0] PDD_C_OD_MASK    = 8'hFF;
    localparam logic [7:0] PDD_D_PIN_MASK   = 8'h07;

    // Pin 7 of the third port doubles as bus enable input
    localparam int PDD_BUS_EN_BIT = 7;

    // Whole state of the top level
    typedef struct packed {
        logic [3:0][7:0] dout_r;     // Output latches, ports A..D
        logic [3:0][7:0] dir_r;      // Direction, ports A..D
        logic [3:0][7:0] drv_r;      // Drive select, ports A..D
        logic [1:0][7:0] ctrl_r;     // Mode control, ports A and B
        logic [7:0]      rdata_r;    // Read answer
        logic [1:0][7:0] addr_in_r;  // Captured high address, A and B
        logic            ale_d_r;    // Strobe history for edge detect
        logic            bus_en_r;   // Bus enable input level
        logic [7:0]      nmx_din_r;  // Data bus read path on port A
    } pdd_state_t;

endpackage : pdd_pkg

// ### hdl/pdd_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin levels
module pdd_sync
    import pdd_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,    // Core clock
    input  wire logic         rst_b,  // Async reset, active low
    input  wire logic [W-1:0] d,      // Asynchronous pin levels
    output logic      [W-1:0] q       // Synchronised levels
);

    typedef struct packed {
        logic [W-1:0] meta_r;
        logic [W-1:0] sync_r;
    } pdd_sync_t;

    pdd_sync_t st_r;
    pdd_sync_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt        = st_r;
        st_nxt.meta_r = d;
        st_nxt.sync_r = st_r.meta_r;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.sync_r;

endmodule : pdd_sync

// ### hdl/pdd_pad.sv
`timescale 1ns/10ps
// Registered pad driver for one port
module pdd_pad
    import pdd_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,      // Core clock
    input  wire logic         rst_b,    // Async reset, active low
    input  wire logic [W-1:0] val,      // Value to present
    input  wire logic [W-1:0] en,       // Pin is to be driven
    input  wire logic [W-1:0] od,       // Open-drain select
    input  wire logic [W-1:0] fast,     // Fast slew select
    output logic      [W-1:0] pin_o,    // Pad output level
    output logic      [W-1:0] pin_oe,   // Pad output enable
    output logic      [W-1:0] pin_fast  // Pad slew control
);

    typedef struct packed {
        logic [W-1:0] o_r;
        logic [W-1:0] oe_r;
        logic [W-1:0] fast_r;
    } pdd_pad_t;

    pdd_pad_t st_r;
    pdd_pad_t st_nxt;

    // Open drain only ever pulls low; a one floats for the pull-up
    always_comb begin
        st_nxt        = st_r;
        st_nxt.fast_r = fast;
        for (int i = 0; i < W; i++) begin
            if (od[i]) begin
                st_nxt.o_r[i]  = 1'b0;
                st_nxt.oe_r[i] = en[i] & ~val[i];
            end else begin
                st_nxt.o_r[i]  = val[i];
                st_nxt.oe_r[i] = en[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_o    = st_r.o_r;
    assign pin_oe   = st_r.oe_r;
    assign pin_fast = st_r.fast_r;

endmodule : pdd_pad

// ### hdl/pdd_top.sv
`timescale 1ns/10ps
// Overview of operation
// - A drive select bit of one on an open-drain capable pin makes it open drain, else push-pull.
// - A drive select bit of one on a slew-capable pin selects fast slew, zero selects slow.
// - On ports A and B bits 7..4 select open drain and bits 3..0 select fast slew.
// - Port D has three pins; drive bits 2..0 set slew and bits 7..3 do nothing.
// - Every port C pin can be set open drain by its drive select bit.
// - Reading the data-in location returns the current pin levels, not latched; port A reads zero while it is the data bus.
// - The output latch holds written data and drives a pin when its direction bit or output-enable term is one.
// - Reading the output latch returns the last written value, not the pin; port D keeps only bits 2..0.
// - Ports A and B can carry logic array outputs onto their pins.
// - High address pins on ports A and B may be captured by the address strobe.
// - Only port A serves as the 8-bit data bus for a non-multiplexed host.
// - Port C pins given to JTAG are removed from all other I/O use.
// - Ports C and D have no address output and no mode control register.
// - Port C pin 7 can be selected as the data bus enable input.
// - Direction one is output, zero is input, and every pin is an input after reset.
// - On ports A and B control zero is general I/O and one is latched address output.
module pdd_top
    import pdd_pkg::*;
(
    input  wire logic       clk,             // Core clock, 125 MHz
    input  wire logic       rst_b,           // Async reset, active low
    // Register access from the microcontroller
    input  wire logic       bus_cs,          // Register space selected
    input  wire logic       bus_wr,          // Write strobe
    input  wire logic       bus_rd,          // Read strobe
    input  wire logic [7:0] bus_addr,        // Register offset
    input  wire logic [7:0] bus_wdata,       // Write data
    output logic      [7:0] bus_rdata,       // Read data
    // Port A pins
    input  wire logic [7:0] port_a_pin_i,    // Pin levels
    output logic      [7:0] port_a_pin_o,    // Pin drive value
    output logic      [7:0] port_a_pin_oe,   // Pin drive enable
    output logic      [7:0] port_a_fast,     // Fast slew select
    // Port B pins
    input  wire logic [7:0] port_b_pin_i,    // Pin levels
    output logic      [7:0] port_b_pin_o,    // Pin drive value
    output logic      [7:0] port_b_pin_oe,   // Pin drive enable
    output logic      [7:0] port_b_fast,     // Fast slew select
    // Port C pins
    input  wire logic [7:0] port_c_pin_i,    // Pin levels
    output logic      [7:0] port_c_pin_o,    // Pin drive value
    output logic      [7:0] port_c_pin_oe,   // Pin drive enable
    // Port D pins
    input  wire logic [2:0] port_d_pin_i,    // Pin levels
    output logic      [2:0] port_d_pin_o,    // Pin drive value
    output logic      [2:0] port_d_pin_oe,   // Pin drive enable
    output logic      [2:0] port_d_fast,     // Fast slew select
    // Logic array hookup
    input  wire logic [7:0] gla_sel_a,       // Port A pins owned by array
    input  wire logic [7:0] gla_val_a,       // Array outputs for port A
    input  wire logic [7:0] gla_sel_b,       // Port B pins owned by array
    input  wire logic [7:0] gla_val_b,       // Array outputs for port B
    input  wire logic [7:0] pt_oe_a,         // Output-enable terms, A
    input  wire logic [7:0] pt_oe_b,         // Output-enable terms, B
    input  wire logic [7:0] pt_oe_c,         // Output-enable terms, C
    input  wire logic [2:0] pt_oe_d,         // Output-enable terms, D
    // Address functions
    input  wire logic [7:0] addr_out_a,      // Latched address for A
    input  wire logic [7:0] addr_out_b,      // Latched address for B
    input  wire logic       ale_pin,         // Address strobe pin
    input  wire logic       addr_in_latch,   // Capture on strobe edge
    output logic      [7:0] addr_in_a,       // High address from A
    output logic      [7:0] addr_in_b,       // High address from B
    // Non-multiplexed data bus on port A
    input  wire logic       nonmux_bus,      // Port A is the data bus
    input  wire logic [7:0] nonmux_wdata,    // Data to host
    input  wire logic       nonmux_oe,       // Drive data to host
    output logic      [7:0] nonmux_din,      // Data from host
    // Port C special functions
    input  wire logic [7:0] jtag_pin_mask,   // Pins owned by JTAG
    input  wire logic       bus_en_select,   // Pin 7 is bus enable
    output logic            bus_enable_input // Bus enable level
);

    // Whole block state and its next value
    pdd_state_t st_r;
    pdd_state_t st_nxt;

    // Synchronised pins and decode helpers
    logic [PDD_SYNC_W-1:0] pin_sync;
    logic [7:0]            pa_s;
    logic [7:0]            pb_s;
    logic [7:0]            pc_s;
    logic [2:0]            pd_s;
    logic                  ale_s;
    logic [7:0]            c_free;
    logic [1:0]            sel;
    logic [7:0]            din_val;

    // Pad requests, one register ahead of the pins
    logic [7:0] a_val;
    logic [7:0] a_en;
    logic [7:0] b_val;
    logic [7:0] b_en;
    logic [7:0] c_val;
    logic [7:0] c_en;
    logic [2:0] d_val;
    logic [2:0] d_en;

    // All pin inputs and the strobe cross into the clock domain together
    // One shared chain keeps pins and strobe on equal latency;
    // bus and array inputs are on this clock and skip it
    pdd_sync #(
        .W (PDD_SYNC_W)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({ale_pin, port_d_pin_i, port_c_pin_i,
                 port_b_pin_i, port_a_pin_i}),
        .q     (pin_sync)
    );

    // Slices follow the concatenation order above
    assign pa_s  = pin_sync[7:0];
    assign pb_s  = pin_sync[15:8];
    assign pc_s  = pin_sync[23:16];
    assign pd_s  = pin_sync[26:24];
    assign ale_s = pin_sync[27];
    assign sel   = bus_addr[1:0];

    // Port C pins still free for general I/O
    // Ownership is static set-up; masks drive and data-in alike
    always_comb begin
        c_free = ~jtag_pin_mask;
        if (bus_en_select) begin
            c_free[PDD_BUS_EN_BIT] = 1'b0;
        end
    end

    // Live pin levels seen through the data-in locations
    // Still two edges behind the pin, plus one for the read
    always_comb begin
        din_val = PDD_UNMAPPED;
        if (sel == PDD_PA) begin
            din_val = nonmux_bus ? PDD_RST_VAL : pa_s;
        end else if (sel == PDD_PB) begin
            din_val = pb_s;
        end else if (sel == PDD_PC) begin
            din_val = pc_s & c_free;
        end else begin
            din_val = {5'h00, pd_s};
        end
    end

    // Register writes, reads and capture logic
    always_comb begin
        st_nxt = st_r;
        // Writes; only ports A and B own a mode control register
        // Reads below use st_r, so a same-cycle read sees old data
        // Writes to data-in offsets fall through and are ignored
        if (bus_cs && bus_wr) begin
            if (bus_addr[7:2] == PDD_CTRL_BASE[7:2]) begin
                if (sel == PDD_PA || sel == PDD_PB) begin
                    st_nxt.ctrl_r[sel[0]] = bus_wdata;
                end
            end else if (bus_addr[7:2] == PDD_DOUT_BASE[7:2]) begin
                st_nxt.dout_r[sel] = bus_wdata;
            end else if (bus_addr[7:2] == PDD_DIR_BASE[7:2]) begin
                st_nxt.dir_r[sel] = bus_wdata;
            end else if (bus_addr[7:2] == PDD_DRV_BASE[7:2]) begin
                st_nxt.drv_r[sel] = bus_wdata;
            end
            // Port D keeps only its three pins
            // Readback then shows only what the pins can use
            if (sel == PDD_PD) begin
                st_nxt.dout_r[PDD_PD] = st_nxt.dout_r[PDD_PD]
                                      & PDD_D_PIN_MASK;
                st_nxt.dir_r[PDD_PD]  = st_nxt.dir_r[PDD_PD]
                                      & PDD_D_PIN_MASK;
                st_nxt.drv_r[PDD_PD]  = st_nxt.drv_r[PDD_PD]
                                      & PDD_D_PIN_MASK;
            end
        end
        // Reads answer the cycle after the strobe and then hold
        // Unmapped offsets and absent registers answer zero
        if (bus_cs && bus_rd) begin
            if (bus_addr[7:2] == PDD_DIN_BASE[7:2]) begin
                st_nxt.rdata_r = din_val;
            end else if (bus_addr[7:2] == PDD_CTRL_BASE[7:2]) begin
                if (sel == PDD_PA || sel == PDD_PB) begin
                    st_nxt.rdata_r = st_r.ctrl_r[sel[0]];
                end else begin
                    st_nxt.rdata_r = PDD_UNMAPPED;
                end
            end else if (bus_addr[7:2] == PDD_DOUT_BASE[7:2]) begin
                st_nxt.rdata_r = st_r.dout_r[sel];
            end else if (bus_addr[7:2] == PDD_DIR_BASE[7:2]) begin
                st_nxt.rdata_r = st_r.dir_r[sel];
            end else if (bus_addr[7:2] == PDD_DRV_BASE[7:2]) begin
                st_nxt.rdata_r = st_r.drv_r[sel];
            end else begin
                st_nxt.rdata_r = PDD_UNMAPPED;
            end
        end
        // High address inputs: captured on the strobe's rising edge,
        // or followed every cycle when capture is off
        // Pins share the strobe's sync delay, so they need only be stable as the strobe rises
        st_nxt.ale_d_r = ale_s;
        if (!addr_in_latch || (ale_s && !st_r.ale_d_r)) begin
            st_nxt.addr_in_r[0] = pa_s;
            st_nxt.addr_in_r[1] = pb_s;
        end
        // Bus enable reads low whenever the pin is not assigned to it,
        // and a JTAG claim on the pin wins over the bus enable
        st_nxt.bus_en_r  = bus_en_select
                         & ~jtag_pin_mask[PDD_BUS_EN_BIT]
                         & pc_s[PDD_BUS_EN_BIT];
        st_nxt.nmx_din_r = nonmux_bus ? pa_s : PDD_RST_VAL;
    end

    // Port A: data bus, address out, logic array, then general I/O
    // Data bus first, so a stale latch never fights the host
    // Array-owned pins are always enabled
    always_comb begin
        for (int i = 0; i < PDD_PIN_W; i++) begin
            if (nonmux_bus) begin
                a_val[i] = nonmux_wdata[i];
                a_en[i]  = nonmux_oe;
            end else if (st_r.ctrl_r[0][i]) begin
                a_val[i] = addr_out_a[i];
                a_en[i]  = st_r.dir_r[PDD_PA][i] | pt_oe_a[i];
            end else if (gla_sel_a[i]) begin
                a_val[i] = gla_val_a[i];
                a_en[i]  = 1'b1;
            end else begin
                a_val[i] = st_r.dout_r[PDD_PA][i];
                a_en[i]  = st_r.dir_r[PDD_PA][i] | pt_oe_a[i];
            end
        end
    end

    // Port B: address out, logic array, then general I/O
    // Same order as port A, without the data bus
    always_comb begin
        for (int i = 0; i < PDD_PIN_W; i++) begin
            if (st_r.ctrl_r[1][i]) begin
                b_val[i] = addr_out_b[i];
                b_en[i]  = st_r.dir_r[PDD_PB][i] | pt_oe_b[i];
            end else if (gla_sel_b[i]) begin
                b_val[i] = gla_val_b[i];
                b_en[i]  = 1'b1;
            end else begin
                b_val[i] = st_r.dout_r[PDD_PB][i];
                b_en[i]  = st_r.dir_r[PDD_PB][i] | pt_oe_b[i];
            end
        end
    end

    // Ports C and D: general I/O only, reserved pins never driven
    // Port D has no open drain, hence the zero select below
    always_comb begin
        c_val = st_r.dout_r[PDD_PC];
        c_en  = (st_r.dir_r[PDD_PC] | pt_oe_c) & c_free;
        d_val = st_r.dout_r[PDD_PD][2:0];
        d_en  = st_r.dir_r[PDD_PD][2:0] | pt_oe_d;
    end

    // Upper nibble is open drain, lower nibble is slew
    // Each pad adds one edge between state and pin
    // Open drain pins rely on the external pull-up
    pdd_pad #(
        .W (PDD_PIN_W)
    ) u_pad_a (
        .clk      (clk),
        .rst_b    (rst_b),
        .val      (a_val),
        .en       (a_en),
        .od       (st_r.drv_r[PDD_PA] & PDD_AB_OD_MASK),
        .fast     (st_r.drv_r[PDD_PA] & PDD_AB_SLEW_MASK),
        .pin_o    (port_a_pin_o),
        .pin_oe   (port_a_pin_oe),
        .pin_fast (port_a_fast)
    );

    // Port B shares the drive layout of port A
    pdd_pad #(
        .W (PDD_PIN_W)
    ) u_pad_b (
        .clk      (clk),
        .rst_b    (rst_b),
        .val      (b_val),
        .en       (b_en),
        .od       (st_r.drv_r[PDD_PB] & PDD_AB_OD_MASK),
        .fast     (st_r.drv_r[PDD_PB] & PDD_AB_SLEW_MASK),
        .pin_o    (port_b_pin_o),
        .pin_oe   (port_b_pin_oe),
        .pin_fast (port_b_fast)
    );

    // Port C has no slew control, so the slew output is left unused
    // All eight drive bits written for port C go to the open-drain select
    pdd_pad #(
        .W (PDD_PIN_W)
    ) u_pad_c (
        .clk      (clk),
        .rst_b    (rst_b),
        .val      (c_val),
        .en       (c_en),
        .od       (st_r.drv_r[PDD_PC] & PDD_C_OD_MASK),
        .fast     (PDD_RST_VAL),
        .pin_o    (port_c_pin_o),
        .pin_oe   (port_c_pin_oe),
        .pin_fast ()
    );

    // Three-pin pad for port D, slew only
    pdd_pad #(
        .W (PDD_D_W)
    ) u_pad_d (
        .clk      (clk),
        .rst_b    (rst_b),
        .val      (d_val),
        .en       (d_en),
        .od       (3'h0),
        .fast     (st_r.drv_r[PDD_PD][2:0]),
        .pin_o    (port_d_pin_o),
        .pin_oe   (port_d_pin_oe),
        .pin_fast (port_d_fast)
    );

    // Everything clears to zero, so every pin starts as an input
    // Constants only, so release needs nothing but a running clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign bus_rdata        = st_r.rdata_r;
    assign addr_in_a        = st_r.addr_in_r[0];
    assign addr_in_b        = st_r.addr_in_r[1];
    assign bus_enable_input = st_r.bus_en_r;
    assign nonmux_din       = st_r.nmx_din_r;

endmodule : pdd_top

// ### dv/pdd_mcu.sv
`timescale 1ns/10ps
// Host model of the register bus
module pdd_mcu
    import pdd_pkg::*;
(
    input  wire logic       clk,       // Core clock
    input  wire logic [7:0] bus_rdata, // Read data
    output logic            bus_cs,    // Select
    output logic            bus_wr,    // Write strobe
    output logic            bus_rd,    // Read strobe
    output logic      [7:0] bus_addr,  // Offset
    output logic      [7:0] bus_wdata  // Write data
);
    // Quiet bus at start
    initial begin
        bus_cs    = 1'b0;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_addr  = 8'hA5;
        bus_wdata = 8'h5A;
    end

    // Released lines flip so a stale value never looks valid
    task idle();
        bus_cs    = 1'b0;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_addr  = ~bus_addr;
        bus_wdata = ~bus_wdata;
        @(posedge clk);
        #1;
    endtask : idle

    // Starts just after an edge; held through the next, no gap after
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus_cs    = 1'b1;
        bus_wr    = 1'b1;
        bus_rd    = 1'b0;
        bus_addr  = a;
        bus_wdata = d;
        @(posedge clk);
        #1;
    endtask : wr

    // Answer is settled one small step after the sampling edge
    task rd(input logic [7:0] a, output logic [7:0] d);
        bus_cs    = 1'b1;
        bus_wr    = 1'b0;
        bus_rd    = 1'b1;
        bus_addr  = a;
        @(posedge clk);
        #1;
        d = bus_rdata;
    endtask : rd
endmodule : pdd_mcu

// ### dv/pdd_top_sva.sv
`timescale 1ns/10ps
// Port-level checks on the register bus and pad outputs
module pdd_top_sva
    import pdd_pkg::*;
(
    input wire logic       clk,              // Core clock
    input wire logic       rst_b,            // Async reset
    input wire logic       bus_cs,           // Select
    input wire logic       bus_wr,           // Write strobe
    input wire logic       bus_rd,           // Read strobe
    input wire logic [7:0] bus_addr,         // Offset
    input wire logic [7:0] bus_wdata,        // Write data
    input wire logic [7:0] bus_rdata,        // Read data
    input wire logic [7:0] port_a_fast,      // Slew A
    input wire logic [7:0] port_b_fast,      // Slew B
    input wire logic [7:0] port_c_pin_oe,    // Enable C
    input wire logic [7:0] jtag_pin_mask,    // JTAG pins
    input wire logic [2:0] port_d_pin_oe,    // Enable D
    input wire logic [2:0] port_d_fast,      // Slew D
    input wire logic [2:0] pt_oe_d,          // Terms D
    input wire logic       bus_en_select,    // Pin 7 select
    input wire logic       bus_enable_input  // Bus enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Bus steps
    sequence s_wr(logic [7:0] a);
        bus_cs && bus_wr && bus_addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        bus_cs && bus_rd && bus_addr == a;
    endsequence

    a_rdata_wr_rd: assert property (s_wr(8'h08) ##1 s_rd(8'h08)
        |=> bus_rdata == $past(bus_wdata, 2)) else $error("readback");
    a_cd_ctrl_zero: assert property (s_rd(8'h06) or s_rd(8'h07)
        |=> bus_rdata == 8'h00) else $error("ctrl C/D not zero");
    a_unmapped_zero: assert property (bus_cs && bus_rd && bus_addr > 8'h13
        |=> bus_rdata == 8'h00) else $error("unmapped not zero");
    a_ab_slew_only: assert property (port_a_fast[7:4] == 4'h0
        && port_b_fast[7:4] == 4'h0) else $error("slew on od bits");
    a_jtag_no_drive: assert property ($stable(jtag_pin_mask)
        |-> (port_c_pin_oe & jtag_pin_mask) == 8'h00) else $error("jtag");
    // Pads lag the register by one edge
    a_dir_d_drive: assert property (s_wr(8'h0F) |-> ##2
        port_d_pin_oe == ($past(bus_wdata[2:0], 2) | pt_oe_d))
        else $error("dir D");
    a_d_slew_set: assert property (s_wr(8'h13) |-> ##2
        port_d_fast == $past(bus_wdata[2:0], 2)) else $error("slew D");
    a_bus_en_gate: assert property (!$past(bus_en_select)
        |-> !bus_enable_input) else $error("bus enable leak");
endmodule : pdd_top_sva

bind pdd_top pdd_top_sva u_sva (.*);

// ### dv/pdd_top_tb.sv
`timescale 1ns/10ps
module pdd_top_tb
    import pdd_pkg::*;
;
    logic       clk = 1'b0, rst_b = 1'b0, ale_pin = 1'b0;
    logic       addr_in_latch = 1'b0, nonmux_bus = 1'b0, nonmux_oe = 1'b0;
    logic       bus_en_select = 1'b0, bus_cs, bus_wr, bus_rd;
    logic       bus_enable_input;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, v, nonmux_din;
    logic [7:0] port_a_pin_i, port_a_pin_o, port_a_pin_oe, port_a_fast;
    logic [7:0] port_b_pin_i, port_b_pin_o, port_b_pin_oe, port_b_fast;
    logic [7:0] port_c_pin_i, port_c_pin_o, port_c_pin_oe;
    logic [7:0] addr_in_a, addr_in_b, a_ext = 8'h00, b_ext = 8'h00;
    logic [7:0] c_ext = 8'hFF, gla_sel_b = 8'h00, gla_val_b = 8'h00;
    logic [7:0] pt_oe_b = 8'h00, addr_out_a = 8'h00, nonmux_wdata = 8'h00;
    logic [7:0] jtag_pin_mask = 8'h00;
    // Unused array hookups held quiet
    logic [7:0] gla_sel_a = 8'h00, gla_val_a = 8'h00, pt_oe_a = 8'h00;
    logic [7:0] pt_oe_c = 8'h00, addr_out_b = 8'h00;
    logic [2:0] port_d_pin_i, port_d_pin_o, port_d_pin_oe, port_d_fast;
    logic [2:0] pt_oe_d = 3'h0, d_ext = 3'h5;
    int         n_errors = 0, n_tests = 0;
    // Rows: offset, write data, expected readback
    logic [23:0] rows [11] = '{
        24'h08A5A5, 24'h0BFF07, 24'h0C3C3C, 24'h0FFF07,
        24'h105A5A, 24'h13FF07, 24'h048181, 24'h06FF00,
        24'h07FF00, 24'h12FFFF, 24'h14FF00};

    // Pin wires: driven level when enabled, else the outside level
    assign port_a_pin_i = (port_a_pin_oe & port_a_pin_o)
                        | (~port_a_pin_oe & a_ext);
    assign port_b_pin_i = (port_b_pin_oe & port_b_pin_o)
                        | (~port_b_pin_oe & b_ext);
    assign port_c_pin_i = (port_c_pin_oe & port_c_pin_o)
                        | (~port_c_pin_oe & c_ext);
    assign port_d_pin_i = (port_d_pin_oe & port_d_pin_o)
                        | (~port_d_pin_oe & d_ext);

    pdd_top DUT (.*);
    pdd_mcu M (.*);

    initial begin
        forever #4 clk = ~clk;
    end

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task give_verdict();
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // Whole run is about a hundred cycles
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end

    initial begin
        cyc(10);
        rst_b = 1'b1;
        for (int i = 0; i < 11; i++) begin
            M.wr(rows[i][23:16], rows[i][15:8]);
            M.rd(rows[i][23:16], v);
            chk(v, rows[i][7:0]);
        end
        // Second reset in mid-run clears everything
        M.idle();
        rst_b = 1'b0;
        cyc(2);
        chk(port_a_pin_oe | port_c_pin_oe, 8'h00);
        rst_b = 1'b1;
        M.rd(8'h0C, v);
        chk(v, 8'h00);
        pt_oe_d = 3'h1;
        cyc(2);
        chk({5'h00, port_d_pin_oe}, 8'h01);
        M.wr(8'h0B, 8'hFF);
        M.idle();
        cyc(1);
        chk({5'h00, port_d_pin_o}, 8'h07);
        // Data-in follows the pins, no latching
        b_ext = 8'h96;
        cyc(3);
        M.rd(8'h01, v);
        chk(v, 8'h96);
        b_ext = 8'h69;
        M.idle();
        cyc(3);
        M.rd(8'h01, v);
        chk(v, 8'h69);
        // Port C open drain: ones release, zeros pull low
        M.wr(8'h12, 8'hFF);
        M.wr(8'h0A, 8'h0F);
        M.wr(8'h0E, 8'hFF);
        M.idle();
        cyc(1);
        chk(port_c_pin_oe, 8'hF0);
        chk(port_c_pin_o, 8'h00);
        jtag_pin_mask = 8'h30;
        cyc(3);
        chk(port_c_pin_oe, 8'hC0);
        M.rd(8'h02, v);
        chk(v, 8'h0F);
        M.rd(8'h0A, v);
        chk(v, 8'h0F);
        bus_en_select = 1'b1;
        M.idle();
        cyc(3);
        chk(port_c_pin_oe, 8'h40);
        chk({7'h00, bus_enable_input}, 8'h01);
        jtag_pin_mask = 8'h80;
        cyc(2);
        chk({7'h00, bus_enable_input}, 8'h00);
        bus_en_select = 1'b0;
        jtag_pin_mask = 8'h00;
        // Port A: open drain high nibble, fast slew low nibble
        M.wr(8'h10, 8'hFF);
        M.wr(8'h08, 8'hF5);
        M.wr(8'h0C, 8'hFF);
        M.idle();
        cyc(1);
        chk(port_a_pin_oe, 8'h0F);
        chk(port_a_pin_o, 8'h05);
        chk(port_a_fast, 8'h0F);
        addr_out_a = 8'h3C;
        M.wr(8'h04, 8'hFF);
        M.idle();
        cyc(1);
        chk(port_a_pin_oe, 8'hCF);
        chk(port_a_pin_o, 8'h0C);
        M.wr(8'h04, 8'h00);
        M.wr(8'h10, 8'h00);
        // Port B: product terms low half, logic array high half
        pt_oe_b = 8'h0F;
        gla_sel_b = 8'hF0;
        gla_val_b = 8'hA0;
        M.wr(8'h09, 8'h55);
        M.idle();
        cyc(1);
        chk(port_b_pin_oe, 8'hFF);
        chk(port_b_pin_o, 8'hA5);
        M.wr(8'h11, 8'h3C);
        M.idle();
        cyc(1);
        chk(port_b_fast, 8'h0C);
        chk(port_b_pin_oe, 8'hDF);
        // Port A as the host data bus
        nonmux_bus = 1'b1;
        nonmux_oe = 1'b1;
        nonmux_wdata = 8'h5A;
        cyc(2);
        chk(port_a_pin_o, 8'h5A);
        chk(port_a_pin_oe, 8'hFF);
        nonmux_oe = 1'b0;
        a_ext = 8'hC3;
        cyc(4);
        chk(nonmux_din, 8'hC3);
        chk(addr_in_a, 8'hC3);
        M.rd(8'h00, v);
        chk(v, 8'h00);
        nonmux_bus = 1'b0;
        // High address captured on the strobe, then held
        pt_oe_b = 8'h00;
        gla_sel_b = 8'h00;
        addr_in_latch = 1'b1;
        b_ext = 8'h12;
        M.idle();
        cyc(3);
        ale_pin = 1'b1;
        cyc(4);
        chk(addr_in_b, 8'h12);
        chk(addr_in_a, 8'hF5);
        b_ext = 8'h34;
        cyc(4);
        chk(addr_in_b, 8'h12);
        give_verdict();
    end
endmodule : pdd_top_tb
